// file: ddc_device.sv
/*
  Converter end: eight-preset oscillator, real-to-complex mixer,
  half-sample delay and the switchable decimation chain.
  Assumes one converter sample per clock and configuration from
  logic on the same clock; only the preset pins are asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none
module ddc_device
  import ddc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic [SAMPLE_W-1:0] sample_in,
  output logic      [PSEL_W-1:0]   active_preset,
  ddc_link_if.device               link
);
  typedef struct packed {
    logic [PSEL_W-1:0]                  pins_meta;
    logic [PSEL_W-1:0]                  pins_sync;
    logic [NUM_PRESETS-1:0][TW_W-1:0]   acc;
    logic [NUM_PRESETS-1:0][RDIV_W-1:0] res;
    logic [DL_DEPTH-1:0][IW-1:0]        dl_i;
    logic [DL_DEPTH-1:0][IW-1:0]        dl_q;
    logic                               del_v;
    logic [IW-1:0]                      del_i;
    logic [IW-1:0]                      del_q;
    logic [PSEL_W-1:0]                  sel;
    logic                               out_v;
    logic [OUT_W-1:0]                   out_i;
    logic [OUT_W-1:0]                   out_q;
    logic [OVR_W-1:0]                   out_ovr;
  } dev_t;

  dev_t                       st;
  dev_t                       next_st;
  logic [PSEL_W-1:0]          sel_now;
  logic                       rat_on;
  logic [PROD_W-1:0]          prod;
  logic [PROD_W-1:0]          nq;
  logic signed [PROD_W:0]     err;
  logic signed [PROD_W:0]     t;
  logic signed [PROD_W:0]     rd;
  logic [TW_W-1:0]            carry;
  logic [TW_W-1:0]            phase;
  logic [LUT_W-1:0]           ph;
  logic signed [TRIG_W-1:0]   cosv;
  logic signed [TRIG_W-1:0]   sinv;
  logic signed [IW-1:0]       mix_i;
  logic signed [IW-1:0]       mix_q;
  logic [DLY_W:0]             dmax;
  logic [DLY_W:0]             dclip;
  logic [DLY_W-1:0]           k;
  logic [DLY_W-1:0]           kn;
  logic [NUM_STAGES-1:0]      mask;
  logic [NUM_STAGES-1:0]      five_sel;
  logic [NUM_STAGES:0]        cv;
  logic [NUM_STAGES:0][IW-1:0] ci;
  logic [NUM_STAGES:0][IW-1:0] cq;

  // Parabolic sine over a half turn; cheaper than a table, spurs are higher
  function automatic logic signed [TRIG_W-1:0] sine(input logic [LUT_W-1:0] p);
    logic [LUT_W-1:0]   x;
    logic [2*LUT_W-1:0] y;
    x = {1'b0, p[LUT_W-2:0]};
    y = x * (HALF_TURN - x);
    if (p[LUT_W-1])
      sine = -$signed({1'b0, y[AMP_SHIFT +: TRIG_W-1]});
    else
      sine = $signed({1'b0, y[AMP_SHIFT +: TRIG_W-1]});
  endfunction : sine

  // Midpoint of two neighbours gives the odd half-sample taps
  function automatic logic [IW-1:0] avg2(input logic [IW-1:0] a, input logic [IW-1:0] b);
    logic [IW:0] s;
    s = {a[IW-1], a} + {b[IW-1], b};
    avg2 = s[IW:1];
  endfunction : avg2

  // Preset choice, pins taken only after two flip-flops
  always_comb
  begin
    sel_now = link.select_source ? link.preset_select_field : st.pins_sync;
  end

  // All eight accumulators step every clock, residual keeps rational mode exact
  always_comb
  begin
    next_st           = st;
    next_st.pins_meta = link.preset_select_pins;
    next_st.pins_sync = st.pins_meta;
    next_st.sel       = sel_now;
    rat_on = link.rational_mode && (link.rational_divider != '0);
    rd     = $signed({{(PROD_W+1-RDIV_W){1'b0}}, link.rational_divider});
    prod   = '0;
    nq     = '0;
    err    = '0;
    t      = '0;
    carry  = '0;
    for (int p = 0; p < NUM_PRESETS; p++)
    begin
      prod  = link.tuning_word_preset[p] * link.rational_divider;
      nq    = (prod + RAT_ROUND) >> RAT_SHIFT;
      err   = $signed({1'b0, nq} << RAT_SHIFT) - $signed({1'b0, prod});
      t     = $signed({{(PROD_W+1-RDIV_W){1'b0}}, st.res[p]}) + err;
      carry = '0;
      if (rat_on)
      begin
        if (t >= rd)
        begin
          t     = t - rd;
          carry = TW_W'(1);
        end
        else if (t < 0)
        begin
          t     = t + rd;
          carry = '1;
        end
        next_st.res[p] = t[RDIV_W-1:0];
      end
      else
      begin
        next_st.res[p] = '0;
      end
      next_st.acc[p] = st.acc[p] + link.tuning_word_preset[p] + carry;
    end

    // Mixer: real sample times cosine and minus sine of the active preset
    phase = st.acc[sel_now] + {link.phase_offset_preset[sel_now], {PH_W{1'b0}}};
    ph    = phase[TW_W-1 -: LUT_W];
    cosv  = sine(ph + QUARTER_TURN);
    sinv  = sine(ph);
    mix_i = $signed(sample_in) * cosv;
    mix_q = -($signed(sample_in) * sinv);
    next_st.dl_i = {st.dl_i[DL_DEPTH-2:0], mix_i};
    next_st.dl_q = {st.dl_q[DL_DEPTH-2:0], mix_q};

    // Delay in half samples, clipped to twice the decimation minus one
    dmax  = {dec_factor(link.dec_code), 1'b0} - 7'h01;
    dclip = {1'b0, link.filter_delay_setting[sel_now]};
    if (dclip > dmax)
      dclip = dmax;
    k  = dclip[DLY_W:1];
    kn = k + 6'h01;
    next_st.del_v = 1'b1;
    if (dclip[0])
    begin
      next_st.del_i = avg2(st.dl_i[k], st.dl_i[kn]);
      next_st.del_q = avg2(st.dl_q[k], st.dl_q[kn]);
    end
    else
    begin
      next_st.del_i = st.dl_i[k];
      next_st.del_q = st.dl_q[k];
    end

    // Chain result trimmed to 15 bits; over-range bits are always driven to zero
    next_st.out_v = cv[NUM_STAGES];
    if (cv[NUM_STAGES])
    begin
      next_st.out_i   = ci[NUM_STAGES][OUT_MSB -: OUT_W];
      next_st.out_q   = cq[NUM_STAGES][OUT_MSB -: OUT_W];
      next_st.out_ovr = '0;
    end

    // Reinit restarts every accumulator and the delay line from zero
    if (link.link_reinit)
    begin
      next_st.acc   = '0;
      next_st.res   = '0;
      next_st.dl_i  = '0;
      next_st.dl_q  = '0;
      next_st.del_v = 1'b0;
    end
  end

  // Stage selection for the chosen overall decimation
  always_comb
  begin
    mask     = stage_mask(link.dec_code);
    five_sel = {(link.dec_code == DEC_10) || (link.dec_code == DEC_20),
                {(NUM_STAGES-1){1'b0}}};
  end

  assign cv[0] = st.del_v;
  assign ci[0] = st.del_i;
  assign cq[0] = st.del_q;

  // Five slots in a row; unused slots pass samples through
  for (genvar g = 0; g < NUM_STAGES; g++)
  begin : g_stage
    ddc_dec_stage #(
      .W (IW)
    ) u_stage (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .clear     (link.link_reinit),
      .use_stage (mask[g]),
      .rate_five (five_sel[g]),
      .in_v      (cv[g]),
      .in_i      (ci[g]),
      .in_q      (cq[g]),
      .out_v     (cv[g+1]),
      .out_i     (ci[g+1]),
      .out_q     (cq[g+1])
    );
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign active_preset  = st.sel;
  assign link.out_valid = st.out_v;
  assign link.out_i     = st.out_i;
  assign link.out_q     = st.out_q;
  assign link.out_ovr   = st.out_ovr;
endmodule : ddc_device
`default_nettype wire

// file: ddc_pkg.sv
/*
  Constants, register map and decimation tables shared by both ends
  of the down-converter pair.
  Assumes both ends and the bench run on one clock.
*/
package ddc_pkg;
  localparam int NUM_PRESETS = 8;
  localparam int PSEL_W      = 3;
  localparam int TW_W        = 32;
  localparam int PH_W        = 16;
  localparam int DLY_W       = 6;
  localparam int RDIV_W      = 16;
  localparam int SAMPLE_W    = 12;
  localparam int OUT_W       = 15;
  localparam int OVR_W       = 2;
  localparam int IW          = 24;
  localparam int DEC_W       = 3;
  localparam int NUM_STAGES  = 5;
  localparam int DL_DEPTH    = 33;
  localparam int PROD_W      = TW_W + RDIV_W;
  localparam int RAT_SHIFT   = 25;
  localparam int LUT_W       = 12;
  localparam int TRIG_W      = 12;
  localparam int AMP_SHIFT   = 10;
  localparam int OUT_MSB     = 21;
  localparam int FIVE_SHIFT  = 6;
  localparam int APB_AW      = 8;

  localparam logic [PROD_W-1:0] RAT_ROUND        = 48'h0000_0100_0000;
  localparam logic [RDIV_W-1:0] RDIV_ADVISED_MAX = 16'h2000;
  localparam logic [LUT_W-1:0]  HALF_TURN        = 12'h800;
  localparam logic [LUT_W-1:0]  QUARTER_TURN     = 12'h400;
  localparam logic [3:0]        FIVE_MUL         = 4'hd;
  localparam logic [2:0]        STAGE_LAST2      = 3'h1;
  localparam logic [2:0]        STAGE_LAST5      = 3'h4;

  // Overall decimation codes; 6 and 7 fall back to decimation 4
  localparam logic [DEC_W-1:0] DEC_4  = 3'h0;
  localparam logic [DEC_W-1:0] DEC_8  = 3'h1;
  localparam logic [DEC_W-1:0] DEC_10 = 3'h2;
  localparam logic [DEC_W-1:0] DEC_16 = 3'h3;
  localparam logic [DEC_W-1:0] DEC_20 = 3'h4;
  localparam logic [DEC_W-1:0] DEC_32 = 3'h5;

  // Stage slots, bit 0 first: four 2-sample integrate-and-dump slots, then slot 4 over 2 or 5 samples
  localparam logic [NUM_STAGES-1:0] MASK_4  = 5'h18;
  localparam logic [NUM_STAGES-1:0] MASK_8  = 5'h1c;
  localparam logic [NUM_STAGES-1:0] MASK_10 = 5'h14;
  localparam logic [NUM_STAGES-1:0] MASK_16 = 5'h1d;
  localparam logic [NUM_STAGES-1:0] MASK_20 = 5'h15;
  localparam logic [NUM_STAGES-1:0] MASK_32 = 5'h1f;

  // Controller register map (byte addresses)
  localparam logic [APB_AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [APB_AW-1:0] REG_RDIV   = 8'h04;
  localparam logic [APB_AW-1:0] REG_PINS   = 8'h08;
  localparam logic [APB_AW-1:0] REG_SAMPLE = 8'h0c;
  localparam logic [APB_AW-1:0] REG_COUNT  = 8'h10;
  localparam logic [APB_AW-1:0] REG_STATUS = 8'h14;
  localparam logic [2:0]        PAGE_LOW   = 3'h0;
  localparam logic [2:0]        PAGE_TW    = 3'h1;
  localparam logic [2:0]        PAGE_PH    = 3'h2;
  localparam logic [2:0]        PAGE_DLY   = 3'h3;
  localparam int CTRL_RAT     = 0;
  localparam int CTRL_SRC     = 1;
  localparam int CTRL_SEL_LSB = 2;
  localparam int CTRL_DEC_LSB = 5;
  localparam int CTRL_AUTO    = 8;
  localparam int CTRL_REINIT  = 9;
  localparam int STAT_RDIV_HI = 0;
  localparam int STAT_RDIV_Z  = 1;

  function automatic logic [NUM_STAGES-1:0] stage_mask(input logic [DEC_W-1:0] d);
    case (d)
      DEC_8:   stage_mask = MASK_8;
      DEC_10:  stage_mask = MASK_10;
      DEC_16:  stage_mask = MASK_16;
      DEC_20:  stage_mask = MASK_20;
      DEC_32:  stage_mask = MASK_32;
      default: stage_mask = MASK_4;
    endcase
  endfunction : stage_mask

  function automatic logic [DLY_W-1:0] dec_factor(input logic [DEC_W-1:0] d);
    case (d)
      DEC_8:   dec_factor = 6'h08;
      DEC_10:  dec_factor = 6'h0a;
      DEC_16:  dec_factor = 6'h10;
      DEC_20:  dec_factor = 6'h14;
      DEC_32:  dec_factor = 6'h20;
      default: dec_factor = 6'h04;
    endcase
  endfunction : dec_factor
endpackage : ddc_pkg

// file: ddc_link_if.sv
/*
  Link between the down-converter and its configuring controller:
  configuration toward the converter, I/Q samples back.
  Assumes both ends share the clock of the bench.
*/
`timescale 1ns/100ps
`default_nettype none
interface ddc_link_if;
  import ddc_pkg::*;
  logic                                 rational_mode;
  logic                                 select_source;
  logic [PSEL_W-1:0]                    preset_select_field;
  logic [PSEL_W-1:0]                    preset_select_pins;
  logic [DEC_W-1:0]                     dec_code;
  logic [RDIV_W-1:0]                    rational_divider;
  logic [NUM_PRESETS-1:0][TW_W-1:0]     tuning_word_preset;
  logic [NUM_PRESETS-1:0][PH_W-1:0]     phase_offset_preset;
  logic [NUM_PRESETS-1:0][DLY_W-1:0]    filter_delay_setting;
  logic                                 link_reinit;
  logic                                 out_valid;
  logic [OUT_W-1:0]                     out_i;
  logic [OUT_W-1:0]                     out_q;
  logic [OVR_W-1:0]                     out_ovr;

  modport device (
    input  rational_mode, select_source, preset_select_field, preset_select_pins,
    input  dec_code, rational_divider, tuning_word_preset, phase_offset_preset,
    input  filter_delay_setting, link_reinit,
    output out_valid, out_i, out_q, out_ovr
  );
  modport host (
    output rational_mode, select_source, preset_select_field, preset_select_pins,
    output dec_code, rational_divider, tuning_word_preset, phase_offset_preset,
    output filter_delay_setting, link_reinit,
    input  out_valid, out_i, out_q, out_ovr
  );
endinterface : ddc_link_if
`default_nettype wire

// file: ddc_dec_stage.sv
/*
  One complex decimating stage: integrate-and-dump over two or five
  samples, or a one-register pass-through when unused.
  Assumes samples from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module ddc_dec_stage
  import ddc_pkg::*;
#(
  parameter int W = IW
)(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         clear,
  input  wire logic         use_stage,
  input  wire logic         rate_five,
  input  wire logic         in_v,
  input  wire logic [W-1:0] in_i,
  input  wire logic [W-1:0] in_q,
  output logic              out_v,
  output logic [W-1:0]      out_i,
  output logic [W-1:0]      out_q
);
  localparam int SW = W + 3;

  typedef struct packed {
    logic [2:0]    cnt;
    logic [SW-1:0] sum_i;
    logic [SW-1:0] sum_q;
    logic          v;
    logic [W-1:0]  oi;
    logic [W-1:0]  oq;
  } stage_t;

  stage_t               st;
  stage_t               next_st;
  logic [2:0]           last;
  logic signed [SW-1:0] ti;
  logic signed [SW-1:0] tq;

  // Divide by two by shifting, by five through 13/64; gain error is small
  function automatic logic [W-1:0] scale(input logic signed [SW-1:0] s, input logic five);
    logic signed [SW+4:0] m;
    m = s * $signed({1'b0, FIVE_MUL});
    if (five)
      scale = m[FIVE_SHIFT +: W];
    else
      scale = s[1 +: W];
  endfunction : scale

  // One output per two or five accepted inputs
  always_comb
  begin
    next_st   = st;
    next_st.v = 1'b0;
    last      = rate_five ? STAGE_LAST5 : STAGE_LAST2;
    ti        = $signed(st.sum_i) + $signed({{3{in_i[W-1]}}, in_i});
    tq        = $signed(st.sum_q) + $signed({{3{in_q[W-1]}}, in_q});
    if (clear)
    begin
      next_st = '0;
    end
    else if (!use_stage)
    begin
      next_st.v  = in_v;
      next_st.oi = in_i;
      next_st.oq = in_q;
    end
    else if (in_v)
    begin
      if (st.cnt == last)
      begin
        next_st.v     = 1'b1;
        next_st.oi    = scale(ti, rate_five);
        next_st.oq    = scale(tq, rate_five);
        next_st.cnt   = '0;
        next_st.sum_i = '0;
        next_st.sum_q = '0;
      end
      else
      begin
        next_st.sum_i = ti;
        next_st.sum_q = tq;
        next_st.cnt   = st.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign out_v = st.v;
  assign out_i = st.oi;
  assign out_q = st.oq;
endmodule : ddc_dec_stage
`default_nettype wire

// file: ddc_host.sv
/*
  Controller end: APB register bank that configures the converter
  over the link and captures the last output sample.
  Assumes an APB master on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module ddc_host
  import ddc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  ddc_link_if.host               link
);
  typedef struct packed {
    logic                               rat;
    logic                               src;
    logic [PSEL_W-1:0]                  sel;
    logic [DEC_W-1:0]                   dec;
    logic                               auto_reinit;
    logic [RDIV_W-1:0]                  rdiv;
    logic [PSEL_W-1:0]                  pins;
    logic [NUM_PRESETS-1:0][TW_W-1:0]   tw;
    logic [NUM_PRESETS-1:0][PH_W-1:0]   ph;
    logic [NUM_PRESETS-1:0][DLY_W-1:0]  dly;
    logic                               reinit;
    logic [31:0]                        rdata;
    logic [31:0]                        sample;
    logic [31:0]                        count;
  } host_t;

  host_t             st;
  host_t             next_st;
  logic              hit;
  logic [31:0]       rv;
  logic [2:0]        page;
  logic [PSEL_W-1:0] idx;

  // Address decode and read-back value
  always_comb
  begin
    page = paddr[APB_AW-1 -: 3];
    idx  = paddr[2 +: PSEL_W];
    hit  = 1'b1;
    rv   = '0;
    unique case (page)
      PAGE_TW:  rv = st.tw[idx];
      PAGE_PH:  rv[PH_W-1:0] = st.ph[idx];
      PAGE_DLY: rv[DLY_W-1:0] = st.dly[idx];
      PAGE_LOW:
      begin
        if (paddr == REG_CTRL)
        begin
          rv[CTRL_RAT]                  = st.rat;
          rv[CTRL_SRC]                  = st.src;
          rv[CTRL_SEL_LSB +: PSEL_W]    = st.sel;
          rv[CTRL_DEC_LSB +: DEC_W]     = st.dec;
          rv[CTRL_AUTO]                 = st.auto_reinit;
        end
        else if (paddr == REG_RDIV)
          rv[RDIV_W-1:0] = st.rdiv;
        else if (paddr == REG_PINS)
          rv[PSEL_W-1:0] = st.pins;
        else if (paddr == REG_SAMPLE)
          rv = st.sample;
        else if (paddr == REG_COUNT)
          rv = st.count;
        else if (paddr == REG_STATUS)
        begin
          rv[STAT_RDIV_HI] = st.rdiv > RDIV_ADVISED_MAX;
          rv[STAT_RDIV_Z]  = st.rat && (st.rdiv == '0);
        end
        else
          hit = 1'b0;
      end
      default: hit = 1'b0;
    endcase
  end

  // Writes land on the access cycle; reads are registered in setup
  always_comb
  begin
    next_st        = st;
    next_st.reinit = 1'b0;
    if (psel && !penable && !pwrite)
      next_st.rdata = rv;
    if (psel && penable && pwrite && hit)
    begin
      unique case (page)
        PAGE_TW:  next_st.tw[idx] = pwdata;
        PAGE_DLY: next_st.dly[idx] = pwdata[DLY_W-1:0];
        PAGE_PH:
        begin
          next_st.ph[idx] = pwdata[PH_W-1:0];
          next_st.reinit  = st.auto_reinit;
        end
        default:
        begin
          if (paddr == REG_CTRL)
          begin
            next_st.rat         = pwdata[CTRL_RAT];
            next_st.src         = pwdata[CTRL_SRC];
            next_st.sel         = pwdata[CTRL_SEL_LSB +: PSEL_W];
            next_st.dec         = pwdata[CTRL_DEC_LSB +: DEC_W];
            next_st.auto_reinit = pwdata[CTRL_AUTO];
            next_st.reinit      = pwdata[CTRL_REINIT];
          end
          else if (paddr == REG_RDIV)
            next_st.rdiv = pwdata[RDIV_W-1:0];
          else if (paddr == REG_PINS)
            next_st.pins = pwdata[PSEL_W-1:0];
        end
      endcase
    end
    // Newest sample overwrites; software polls the count to see progress
    if (link.out_valid)
    begin
      next_st.sample = {link.out_ovr, link.out_q, link.out_i};
      next_st.count  = st.count + 32'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign prdata  = st.rdata;
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !hit;

  assign link.rational_mode        = st.rat;
  assign link.select_source        = st.src;
  assign link.preset_select_field  = st.sel;
  assign link.preset_select_pins   = st.pins;
  assign link.dec_code             = st.dec;
  assign link.rational_divider     = st.rdiv;
  assign link.tuning_word_preset   = st.tw;
  assign link.phase_offset_preset  = st.ph;
  assign link.filter_delay_setting = st.dly;
  assign link.link_reinit          = st.reinit;
endmodule : ddc_host
`default_nettype wire

// file: ddc_link_props.sv
/* Link checker: output pacing, pulses and over-range bits.
   Assumes the link signals and the shared clock as inputs. */
`timescale 1ns/100ps
`default_nettype none
module ddc_link_props
  import ddc_pkg::*;
(
  input wire logic             clk,
  input wire logic             sys_rst,
  input wire logic [DEC_W-1:0] dec_code,
  input wire logic             link_reinit,
  input wire logic             out_valid,
  input wire logic [OUT_W-1:0] out_i,
  input wire logic [OUT_W-1:0] out_q,
  input wire logic [OVR_W-1:0] out_ovr
);
  // Pulse spacing per code; 6 and 7 act as 4
  localparam logic [7:0] DFAC [8] = '{8'h04, 8'h08, 8'h0a, 8'h10, 8'h14, 8'h20, 8'h04, 8'h04};
  logic [7:0]       gap;
  logic [1:0]       seen;
  logic [DEC_W-1:0] dec_q;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Stale pulses follow a re-time, so spacing counts only after three
  always_ff @(posedge clk)
  begin
    dec_q <= dec_code;
    gap <= (sys_rst || out_valid) ? 8'h01 : gap + 8'h01;
    if (sys_rst || link_reinit || dec_q != dec_code)
      seen <= 2'h0;
    else if (out_valid && seen != 2'h3)
      seen <= seen + 2'h1;
  end
  a_ovr_zero: assert property (out_ovr == 2'h0)
    else $error("over-range bits set");
  a_gap_min: assert property (out_valid |=> !out_valid [*3])
    else $error("pulses too close");
  a_rate_exact: assert property (
    seen == 2'h3 && out_valid && dec_q == dec_code |-> gap == DFAC[dec_code])
    else $error("spacing is not the decimation");
  a_no_drop: assert property (
    seen == 2'h3 && dec_q == dec_code |-> gap <= DFAC[dec_code])
    else $error("output pulse missing");
  a_out_hold: assert property (!out_valid |-> $stable(out_i) && $stable(out_q))
    else $error("output word moved between pulses");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !out_valid [*4])
    else $error("pulse too soon after reset");
  a_reinit_pulse: assert property (link_reinit |=> !link_reinit)
    else $error("reinit longer than one cycle");
  a_reinit_resume: assert property (link_reinit |-> ##[1:100] out_valid)
    else $error("no output after reinit");
endmodule : ddc_link_props
`default_nettype wire

// file: ddc_nco_decimation_bench.sv
/* Bench: both ends on one link, APB stimulus, random samples.
   Assumes package, link, both ends and checker compiled first. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    total_checks++; \
    n_fail += int'((got) !== (ex)); \
    if ((got) !== (ex)) \
      $display("FAIL %s exp %h got %h", nm, ex, got); \
  end
module ddc_nco_decimation_bench
  import ddc_pkg::*;
;
  logic                clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic                hold = 1'b1;
  logic [OUT_W-1:0]    ie;
  logic                pready, pslverr;
  logic [31:0]         pwdata = '0, prdata, tw;
  logic [SAMPLE_W-1:0] sample_in = '0;
  logic [APB_AW-1:0]   paddr = '0;
  logic [PSEL_W-1:0]   active_preset;
  logic [33:0]         exp_q[$], e;
  int                  n_fail = 0, total_checks = 0, n, s;
  int                  dv[6] = '{4, 8, 10, 16, 20, 32};
  ddc_link_if link();
  ddc_device u_ddc_device (.clk(clk), .sys_rst(sys_rst), .sample_in(sample_in),
    .active_preset(active_preset), .link(link));
  ddc_host u_ddc_host (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  ddc_link_props u_ddc_link_props (.clk(clk), .sys_rst(sys_rst), .dec_code(link.dec_code),
    .link_reinit(link.link_reinit), .out_valid(link.out_valid), .out_i(link.out_i),
    .out_q(link.out_q), .out_ovr(link.out_ovr));
  // Clock, and a fresh random converter sample every cycle unless held
  always #2 clk = ~clk;
  always @(posedge clk)
    if (!hold)
      sample_in <= SAMPLE_W'($urandom);
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  // One edge of a bounded wait; a hang ends the run
  task automatic tick(inout int k);
    @(posedge clk);
    k++;
    if (k > 200)
    begin
      n_fail++;
      finish_test();
    end
  endtask : tick
  // One APB transfer; a read expects d back
  task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] d, input logic err);
    int k;
    exp_q.push_back({~w, err, d});
    @(posedge clk);
    paddr <= ad;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do tick(k); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_v(output int m);
    m = 0;
    do tick(m); while (link.out_valid !== 1'b1);
  endtask : wait_v
  // Each finished transfer is matched with the oldest note
  always @(posedge clk)
    if (psel && penable && pready)
    begin
      e = exp_q.pop_front();
      `CHK("pslverr", e[32], pslverr)
      if (e[33])
        `CHK("prdata", e[31:0], prdata)
    end
  initial
  begin
    void'($urandom(61097));
    repeat (6)
      @(posedge clk);
    sys_rst <= 1'b0;
    // Reset value, refused place, divider above the advised limit
    apb(REG_CTRL, 1'b0, 32'h0, 1'b0);
    apb(8'h18, 1'b0, 32'h0, 1'b1);
    apb(REG_RDIV, 1'b1, 32'h2001, 1'b0);
    apb(REG_STATUS, 1'b0, 32'h1, 1'b0);
    // Decimation codes 0 to 5, re-timed; zero tuning leaves Q silent and
    // a held sample gives a known I word once the filters have filled
    for (int c = 0; c < 6; c++)
    begin
      sample_in <= SAMPLE_W'($urandom);
      apb(REG_CTRL, 1'b1, 32'(c) << 5 | 32'h200, 1'b0);
      repeat (4)
        wait_v(n);
      s = $signed(sample_in);
      // Cosine amplitude 1024, output window drops 7 bits; rate five scales 5*13/64
      if (dv[c] % 5 != 0)
        ie = 15'(s * 8);
      else
        ie = 15'((s * 5 * int'(FIVE_MUL)) >>> 3);
      `CHK("period", dv[c], n)
      `CHK("q word", 15'h0, link.out_q)
      `CHK("i word", ie, link.out_i)
      apb(REG_SAMPLE, 1'b0, {17'h0, ie}, 1'b0);
    end
    hold <= 1'b0;
    // Tuning words reach the link whole, delays as six bits; offsets read back narrowed
    for (int p = 0; p < NUM_PRESETS; p++)
    begin
      tw = $urandom;
      apb(8'h40 + 8'(4 * p), 1'b1, tw, 1'b0);
      apb(8'h40 + 8'(4 * p), 1'b0, {16'h0, tw[15:0]}, 1'b0);
      apb(8'h60 + 8'(4 * p), 1'b1, tw, 1'b0);
      apb(8'h20 + 8'(4 * p), 1'b1, tw, 1'b0);
      @(posedge clk);
      `CHK("word", tw, link.tuning_word_preset[p])
      `CHK("delay", tw[5:0], link.filter_delay_setting[p])
    end
    // Pins first, then the register field, choose the preset
    apb(REG_PINS, 1'b1, 32'h5, 1'b0);
    repeat (4)
      @(posedge clk);
    `CHK("pins preset", 3'h5, active_preset)
    apb(REG_RDIV, 1'b1, 32'h0, 1'b0);
    apb(REG_CTRL, 1'b1, 32'haf, 1'b0);
    repeat (2)
      @(posedge clk);
    `CHK("field preset", 3'h3, active_preset)
    // Rational mode with a zero divider is flagged in status
    apb(REG_STATUS, 1'b0, 32'h2, 1'b0);
    finish_test();
  end
endmodule : ddc_nco_decimation_bench
`default_nettype wire
